// file: core/meif_pkg.sv
// Purpose: Constants and types for the motion event flag and mask block
// Assumes: 16-bit registers, one aligned 32-bit Avalon word each
// Notes: Byte address of a register is four times its index
package meif_pkg;

    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [15:0] IDX_ENABLE_A = 16'h742C;
    localparam logic [15:0] IDX_ENABLE_B = 16'h742D;
    localparam logic [15:0] IDX_ENABLE_C = 16'h742E;
    localparam logic [15:0] IDX_FLAGS_A = 16'h742F;
    localparam logic [15:0] IDX_FLAGS_B = 16'h7430;
    localparam logic [15:0] IDX_FLAGS_C = 16'h7431;
    localparam logic [15:0] IDX_COMPAT = 16'h7409;

    // ****************************************************************
    // Bus and field layout
    // ****************************************************************
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int WORD_LSB = 2;

    localparam int A_T1_OVF = 10;
    localparam int A_T1_UNF = 9;
    localparam int A_T1_CMP = 8;
    localparam int A_T1_PER = 7;
    localparam int A_CMP3 = 3;
    localparam int A_CMP2 = 2;
    localparam int A_CMP1 = 1;
    localparam int A_PDP = 0;
    localparam int B_T2_OVF = 3;
    localparam int B_T2_UNF = 2;
    localparam int B_T2_CMP = 1;
    localparam int B_T2_PER = 0;
    localparam int C_CAP3 = 2;
    localparam int C_CAP2 = 1;
    localparam int C_CAP1 = 0;
    localparam int COMPAT_BIT = 0;

    localparam logic [15:0] VALID_A = 16'h078F;
    localparam logic [15:0] VALID_B = 16'h000F;
    localparam logic [15:0] VALID_C = 16'h0007;
    localparam logic [15:0] VALID_COMPAT = 16'h0001;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] RST_ENABLE_A = 16'h0001;
    localparam logic [15:0] RST_ENABLE_B = 16'h0000;
    localparam logic [15:0] RST_ENABLE_C = 16'h0000;
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [15:0] RST_COMPAT = 16'h0000;

    // ****************************************************************
    // Event carriers
    // ****************************************************************
    typedef struct packed {
        logic ovf;
        logic unf;
        logic cmp;
        logic per;
    } meif_timer_evt_s;

    typedef struct packed {
        meif_timer_evt_s timer_one;
        meif_timer_evt_s timer_two;
        logic [2:0] compare_unit;  // [2]=unit 3 .. [0]=unit 1
        logic [2:0] capture_unit;  // [2]=unit 3 .. [0]=unit 1
    } meif_evt_s;

endpackage

// file: core/meif_top.sv
// Purpose: Event interrupt flags, masks and protection trip logic
// Assumes: Event pulses come from sibling units on clk; pins are async
// Notes: Avalon-MM slave, reads take one wait cycle, writes none
//
// Design decision made here: register access over Avalon-MM.
module meif_top (
    input wire logic clk,                             // 200 MHz clock
    input wire logic sys_rst,                         // Sync reset, high
    input wire logic [meif_pkg::ADDR_W-1:0] address,  // Byte address
    input wire logic read,                            // Read request
    input wire logic write,                           // Write request
    input wire logic [3:0] byteenable,                // Byte lanes
    input wire logic [meif_pkg::DATA_W-1:0] writedata, // Write data
    output logic [meif_pkg::DATA_W-1:0] readdata,     // Read data
    output logic waitrequest,                         // Stall master
    input wire meif_pkg::meif_evt_s events,           // Event pulses
    input wire logic power_drive_protect_pin,         // Pin, active low
    input wire logic [2:0] compare_trip_n,            // Trip pins, low
    input wire logic [2:0] compare_trip_enable,       // Trip enables
    output logic power_drive_protect_a,               // Buffer trip
    output logic compat_mode_select,                  // Compat mode bit
    output logic irq                                  // Level interrupt
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic hit(input logic [meif_pkg::ADDR_W-1:0] a,
                                 input logic [15:0] idx);
        hit = (a[meif_pkg::ADDR_W-1:meif_pkg::WORD_LSB] == idx);
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta_r <= 4'hF;
            pin_sync_r <= 4'hF;
        end else begin
            pin_meta_r <= {power_drive_protect_pin, compare_trip_n};
            pin_sync_r <= pin_meta_r;
        end
    end

    logic pdp_low;
    logic trip_hit;
    assign pdp_low = ~pin_sync_r[3];
    assign trip_hit = |(~pin_sync_r[2:0] & compare_trip_enable);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic [15:0] wdata;
    logic [15:0] wmask;
    logic wr_en_a;
    logic wr_en_b;
    logic wr_en_c;
    logic wr_fl_a;
    logic wr_fl_b;
    logic wr_fl_c;
    logic wr_compat;
    logic rd_ack_r;

    assign wdata = writedata[15:0];
    assign wmask = lane_mask(byteenable);
    assign wr_en_a = write && hit(address, meif_pkg::IDX_ENABLE_A);
    assign wr_en_b = write && hit(address, meif_pkg::IDX_ENABLE_B);
    assign wr_en_c = write && hit(address, meif_pkg::IDX_ENABLE_C);
    assign wr_fl_a = write && hit(address, meif_pkg::IDX_FLAGS_A);
    assign wr_fl_b = write && hit(address, meif_pkg::IDX_FLAGS_B);
    assign wr_fl_c = write && hit(address, meif_pkg::IDX_FLAGS_C);
    assign wr_compat = write && hit(address, meif_pkg::IDX_COMPAT);

    // Registered read data costs one wait cycle per read
    assign waitrequest = read && !rd_ack_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_ack_r <= 1'b0;
        end else begin
            rd_ack_r <= read && !rd_ack_r;
        end
    end

    // ****************************************************************
    // Mode and enable registers
    // ****************************************************************
    logic [15:0] enable_a_r;
    logic [15:0] enable_b_r;
    logic [15:0] enable_c_r;
    logic [15:0] compat_r;

    function automatic logic [15:0] rw_upd(input logic [15:0] cur,
                                          input logic [15:0] d,
                                          input logic [15:0] m,
                                          input logic [15:0] valid);
        rw_upd = ((cur & ~m) | (d & m)) & valid;
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_a_r <= meif_pkg::RST_ENABLE_A;
            enable_b_r <= meif_pkg::RST_ENABLE_B;
            enable_c_r <= meif_pkg::RST_ENABLE_C;
        end else begin
            if (wr_en_a) begin
                enable_a_r <= rw_upd(enable_a_r, wdata, wmask,
                                     meif_pkg::VALID_A);
            end
            if (wr_en_b) begin
                enable_b_r <= rw_upd(enable_b_r, wdata, wmask,
                                     meif_pkg::VALID_B);
            end
            if (wr_en_c) begin
                enable_c_r <= rw_upd(enable_c_r, wdata, wmask,
                                     meif_pkg::VALID_C);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compat_r <= meif_pkg::RST_COMPAT;
        end else if (wr_compat) begin
            compat_r <= rw_upd(compat_r, wdata, wmask,
                               meif_pkg::VALID_COMPAT);
        end
    end

    assign compat_mode_select = compat_r[meif_pkg::COMPAT_BIT];

    // ****************************************************************
    // Event flags
    // ****************************************************************
    logic pdp_event;
    logic [15:0] set_a;
    logic [15:0] set_b;
    logic [15:0] set_c;
    logic [15:0] flags_a_r;
    logic [15:0] flags_b_r;
    logic [15:0] flags_c_r;

    // Compat mode uses enabled trips; legacy mode the protection pin
    assign pdp_event = compat_mode_select ? trip_hit : pdp_low;

    always_comb begin
        set_a = '0;
        set_a[meif_pkg::A_T1_OVF] = events.timer_one.ovf;
        set_a[meif_pkg::A_T1_UNF] = events.timer_one.unf;
        set_a[meif_pkg::A_T1_CMP] = events.timer_one.cmp;
        set_a[meif_pkg::A_T1_PER] = events.timer_one.per;
        set_a[meif_pkg::A_CMP3] = events.compare_unit[2];
        set_a[meif_pkg::A_CMP2] = events.compare_unit[1];
        set_a[meif_pkg::A_CMP1] = events.compare_unit[0];
        set_a[meif_pkg::A_PDP] = pdp_event;
        set_b = '0;
        set_b[meif_pkg::B_T2_OVF] = events.timer_two.ovf;
        set_b[meif_pkg::B_T2_UNF] = events.timer_two.unf;
        set_b[meif_pkg::B_T2_CMP] = events.timer_two.cmp;
        set_b[meif_pkg::B_T2_PER] = events.timer_two.per;
        set_c = '0;
        set_c[meif_pkg::C_CAP3] = events.capture_unit[2];
        set_c[meif_pkg::C_CAP2] = events.capture_unit[1];
        set_c[meif_pkg::C_CAP1] = events.capture_unit[0];
    end

    // Set wins over a same-cycle clear so no event is lost
    function automatic logic [15:0] w1c_upd(input logic [15:0] cur,
                                           input logic [15:0] set,
                                           input logic wr,
                                           input logic [15:0] d,
                                           input logic [15:0] m,
                                           input logic [15:0] valid);
        logic [15:0] clr;
        clr = wr ? (d & m) : 16'h0000;
        w1c_upd = ((cur & ~clr) | set) & valid;
    endfunction

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_a_r <= meif_pkg::RST_FLAGS;
            flags_b_r <= meif_pkg::RST_FLAGS;
            flags_c_r <= meif_pkg::RST_FLAGS;
        end else begin
            flags_a_r <= w1c_upd(flags_a_r, set_a, wr_fl_a, wdata, wmask,
                                 meif_pkg::VALID_A);
            flags_b_r <= w1c_upd(flags_b_r, set_b, wr_fl_b, wdata, wmask,
                                 meif_pkg::VALID_B);
            flags_c_r <= w1c_upd(flags_c_r, set_c, wr_fl_c, wdata, wmask,
                                 meif_pkg::VALID_C);
        end
    end

    // ****************************************************************
    // Interrupt and buffer trip outputs
    // ****************************************************************
    logic pdp_en;
    logic trip_r;

    assign pdp_en = enable_a_r[meif_pkg::A_PDP];
    assign irq = |(flags_a_r & enable_a_r) | |(flags_b_r & enable_b_r)
               | |(flags_c_r & enable_c_r);

    // Enable gates the pin path only in legacy mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trip_r <= 1'b0;
        end else begin
            trip_r <= pdp_low && (compat_mode_select || pdp_en);
        end
    end

    assign power_drive_protect_a = trip_r;

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [15:0] rd_mux;
    logic [meif_pkg::DATA_W-1:0] readdata_r;

    always_comb begin
        if (hit(address, meif_pkg::IDX_ENABLE_A)) begin
            rd_mux = enable_a_r;
        end else if (hit(address, meif_pkg::IDX_ENABLE_B)) begin
            rd_mux = enable_b_r;
        end else if (hit(address, meif_pkg::IDX_ENABLE_C)) begin
            rd_mux = enable_c_r;
        end else if (hit(address, meif_pkg::IDX_FLAGS_A)) begin
            rd_mux = flags_a_r;
        end else if (hit(address, meif_pkg::IDX_FLAGS_B)) begin
            rd_mux = flags_b_r;
        end else if (hit(address, meif_pkg::IDX_FLAGS_C)) begin
            rd_mux = flags_c_r;
        end else if (hit(address, meif_pkg::IDX_COMPAT)) begin
            rd_mux = compat_r;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readdata_r <= '0;
        end else if (read && !rd_ack_r) begin
            readdata_r <= {16'h0000, rd_mux};
        end
    end

    assign readdata = readdata_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    reserved_zero_a: assert property (
        (flags_a_r & ~meif_pkg::VALID_A) == 16'h0000
        && (enable_a_r & ~meif_pkg::VALID_A) == 16'h0000
        && (flags_b_r & ~meif_pkg::VALID_B) == 16'h0000)
        else $error("reserved bit set");
    read_lat_a: assert property (
        $rose(read) |-> waitrequest ##1 (!waitrequest && read))
        else $error("read answer not after one wait");
    wr_no_wait_a: assert property (
        write |-> !waitrequest)
        else $error("write stalled");
    rd_data_a: assert property (
        read && !rd_ack_r && hit(address, meif_pkg::IDX_FLAGS_B)
        |=> readdata == {16'h0000, $past(flags_b_r)})
        else $error("flag read data wrong");
    ovf_sets_a: assert property (
        events.timer_one.ovf |=> flags_a_r[meif_pkg::A_T1_OVF])
        else $error("timer one overflow flag not set");
    unf_sets_a: assert property (
        events.timer_one.unf |=> flags_a_r[meif_pkg::A_T1_UNF])
        else $error("timer one underflow flag not set");
    t1_cmp_sets_a: assert property (
        events.timer_one.cmp |=> flags_a_r[meif_pkg::A_T1_CMP])
        else $error("timer one compare flag not set");
    per_sets_a: assert property (
        events.timer_one.per |=> flags_a_r[meif_pkg::A_T1_PER])
        else $error("timer one period flag not set");
    cmp_sets_a: assert property (
        events.compare_unit[2] |=> flags_a_r[meif_pkg::A_CMP3])
        else $error("compare three flag not set");
    set_wins_a: assert property (
        wr_fl_a && events.compare_unit[0] |=> flags_a_r[meif_pkg::A_CMP1])
        else $error("set lost to clear");
    t2_sets_a: assert property (
        events.timer_two.ovf |=> flags_b_r[meif_pkg::B_T2_OVF])
        else $error("timer two overflow flag not set");
    t2_per_a: assert property (
        events.timer_two.per |=> flags_b_r[meif_pkg::B_T2_PER])
        else $error("timer two period flag not set");
    cap_sets_a: assert property (
        events.capture_unit[2] |=> flags_c_r[meif_pkg::C_CAP3])
        else $error("capture three flag not set");
    cap_one_a: assert property (
        events.capture_unit[0] |=> flags_c_r[meif_pkg::C_CAP1])
        else $error("capture one flag not set");
    flag_hold_a: assert property (
        flags_b_r[meif_pkg::B_T2_PER] && !wr_fl_b
        |=> flags_b_r[meif_pkg::B_T2_PER])
        else $error("flag lost without clear");
    clear_one_a: assert property (
        wr_fl_c && wmask[0] && wdata[0]
        && !events.capture_unit[0] |=> !flags_c_r[meif_pkg::C_CAP1])
        else $error("write one did not clear");
    clear_ovf_a: assert property (
        wr_fl_a && wmask[meif_pkg::A_T1_OVF] && wdata[meif_pkg::A_T1_OVF]
        && !events.timer_one.ovf |=> !flags_a_r[meif_pkg::A_T1_OVF])
        else $error("overflow flag not cleared");
    rst_flags_a: assert property (
        $fell(sys_rst) |-> flags_a_r == meif_pkg::RST_FLAGS
        && flags_b_r == meif_pkg::RST_FLAGS
        && flags_c_r == meif_pkg::RST_FLAGS)
        else $error("flag reset value wrong");
    compat_trip_a: assert property (
        compat_mode_select && trip_hit |=> flags_a_r[meif_pkg::A_PDP])
        else $error("compat trip not latched");
    legacy_flag_a: assert property (
        !compat_mode_select && pdp_low |=> flags_a_r[meif_pkg::A_PDP])
        else $error("legacy pin not latched");
    compat_wr_a: assert property (
        wr_compat && wmask[meif_pkg::COMPAT_BIT] |=>
        compat_mode_select == $past(wdata[meif_pkg::COMPAT_BIT]))
        else $error("mode write not stored");
    legacy_gate_a: assert property (
        !compat_mode_select && !pdp_en |=> !power_drive_protect_a)
        else $error("pin path not gated");
    compat_path_a: assert property (
        compat_mode_select && pdp_low |=> power_drive_protect_a)
        else $error("enable gated pin path in compat mode");
    mask_wr_a: assert property (
        wr_en_a && wmask[0] |=> enable_a_r[meif_pkg::A_PDP] == $past(wdata[0]))
        else $error("enable write not stored");
    enable_hold_a: assert property (
        !wr_en_a |=> $stable(enable_a_r))
        else $error("enable changed without write");
    rst_enable_a: assert property (
        $fell(sys_rst) |-> enable_a_r == meif_pkg::RST_ENABLE_A)
        else $error("enable reset value wrong");
    irq_cause_a: assert property (
        events.timer_two.per && enable_b_r[meif_pkg::B_T2_PER] && !wr_en_b
        |=> irq)
        else $error("enabled event gave no irq");
    unused_wr_a: assert property (
        wr_en_b |=> (enable_b_r & ~meif_pkg::VALID_B) == 16'h0000)
        else $error("unused bit stored");

    irq_seen_c: cover property ($rose(irq));
    poll_masked_c: cover property (flags_b_r != 16'h0000 && !enable_b_r[0]);
    compat_trip_c: cover property (compat_mode_select && trip_hit);
    clear_race_c: cover property (wr_fl_a && set_a != 16'h0000);
    pin_trip_c: cover property (power_drive_protect_a);

endmodule

// file: testbench/meif_evt_src.sv
// Purpose: Sibling event sources and protection pins for the flag block
// Assumes: Event pulses last one clk cycle; pins idle high
// Notes: Pins change only when the bench asks, on a clock edge
module meif_evt_src (
    input wire logic clk,                // Block clock
    output meif_pkg::meif_evt_s events,  // One-cycle event pulses
    output logic pin_n,                  // Protection pin, low trips
    output logic [2:0] trip_n            // Compare trips, low trips
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Idle state
    // ****************************************************************
    initial begin
        events = '0;
        pin_n = 1'b1;
        trip_n = 3'h7;
    end

    // ****************************************************************
    // Requests from the bench
    // ****************************************************************
    // Pulse drops at the next edge, so no flag sees a level
    task automatic fire(input meif_pkg::meif_evt_s e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= '0;
    endtask

    task automatic set_pins(input logic p, input logic [2:0] t);
        @(posedge clk);
        pin_n <= p;
        trip_n <= t;
    endtask
endmodule

// file: testbench/motion_event_irq_flags_masks_bench.sv
// Purpose: Self-checking bench for the motion event flag and mask block
// Assumes: Avalon reads take one wait cycle, writes none
// Notes: Pins pass a two-stage synchroniser, so pin waits are padded
module motion_event_irq_flags_masks_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [meif_pkg::ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [meif_pkg::DATA_W-1:0] writedata = '0;
    logic [meif_pkg::DATA_W-1:0] readdata;
    logic waitrequest, pda, compat, irq, pin_n;
    logic [2:0] trip_n;
    logic [2:0] trip_en = 3'h0;
    meif_pkg::meif_evt_s events;
    logic [15:0] q;
    int bad_count = 0;
    int num_checks = 0;

    initial forever #2.5 clk = ~clk;

    meif_top u_dut (.clk(clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .events(events),
        .power_drive_protect_pin(pin_n), .compare_trip_n(trip_n),
        .compare_trip_enable(trip_en), .power_drive_protect_a(pda),
        .compat_mode_select(compat), .irq(irq));
    meif_evt_src u_src (.clk(clk), .events(events), .pin_n(pin_n),
        .trip_n(trip_n));

    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [15:0] d);
        int n;
        n = 0;
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= {16'h0000, d};
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) chk("bus handshake", 16'h0000, 16'h0001);
        q = readdata[15:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [15:0] exp,
                      input string what);
        bus(1'b0, idx, 16'h0000);
        chk(what, q, exp);
    endtask

    // Event vector bit to its flag register and position
    function automatic logic [15:0] flag_reg(input int i);
        if (i >= 10) return meif_pkg::IDX_FLAGS_A;
        if (i >= 6) return meif_pkg::IDX_FLAGS_B;
        if (i >= 3) return meif_pkg::IDX_FLAGS_A;
        return meif_pkg::IDX_FLAGS_C;
    endfunction

    function automatic int flag_bit(input int i);
        if (i >= 10) return i - 3;
        if (i >= 6) return i - 6;
        if (i >= 3) return i - 2;
        return i;
    endfunction

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        logic [15:0] exp;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("irq after reset", {15'h0000, irq}, 16'h0000);
        chk("trip after reset", {15'h0000, pda}, 16'h0000);
        rd(meif_pkg::IDX_ENABLE_A, 16'h0001, "enable_a reset");
        rd(meif_pkg::IDX_FLAGS_A, 16'h0000, "flags_a reset");
        rd(meif_pkg::IDX_FLAGS_B, 16'h0000, "flags_b reset");
        rd(meif_pkg::IDX_FLAGS_C, 16'h0000, "flags_c reset");
        $display("Test reset values done");
        // Every source alone while masked, then zero and one writes
        for (int i = 0; i < 14; i++) begin
            u_src.fire(meif_pkg::meif_evt_s'(14'h0001 << i));
            exp = 16'h0001 << flag_bit(i);
            rd(flag_reg(i), exp, "flag set");
            chk("irq masked", {15'h0000, irq}, 16'h0000);
            wr(flag_reg(i), ~exp);
            rd(flag_reg(i), exp, "flag kept by zero");
            wr(flag_reg(i), 16'hFFFF);
            rd(flag_reg(i), 16'h0000, "flag cleared by one");
        end
        $display("Test flag positions done");
        wr(meif_pkg::IDX_ENABLE_A, 16'hFFFE);
        rd(meif_pkg::IDX_ENABLE_A, 16'h078E, "enable_a bits");
        u_src.fire(meif_pkg::meif_evt_s'(14'h2000));
        @(posedge clk);
        chk("irq enabled", {15'h0000, irq}, 16'h0001);
        wr(meif_pkg::IDX_ENABLE_A, 16'h0000);
        chk("irq masked again", {15'h0000, irq}, 16'h0000);
        rd(meif_pkg::IDX_FLAGS_A, 16'h0400, "flag polled");
        wr(meif_pkg::IDX_FLAGS_A, 16'h0400);
        wr(meif_pkg::IDX_ENABLE_B, 16'hFFFF);
        rd(meif_pkg::IDX_ENABLE_B, 16'h000F, "enable_b bits");
        u_src.fire(meif_pkg::meif_evt_s'(14'h0040));
        @(posedge clk);
        chk("irq timer two", {15'h0000, irq}, 16'h0001);
        wr(meif_pkg::IDX_FLAGS_B, 16'h0001);
        chk("irq after clear", {15'h0000, irq}, 16'h0000);
        wr(meif_pkg::IDX_ENABLE_B, 16'h0000);
        wr(meif_pkg::IDX_ENABLE_C, 16'hFFFF);
        rd(meif_pkg::IDX_ENABLE_C, 16'h0007, "enable_c bits");
        u_src.fire(meif_pkg::meif_evt_s'(14'h0004));
        @(posedge clk);
        chk("irq capture three", {15'h0000, irq}, 16'h0001);
        wr(meif_pkg::IDX_FLAGS_C, 16'h0004);
        chk("irq capture clear", {15'h0000, irq}, 16'h0000);
        wr(meif_pkg::IDX_ENABLE_C, 16'h0000);
        $display("Test interrupt masking done");
        // Legacy mode: enable gates both the interrupt and the pin path
        wr(meif_pkg::IDX_ENABLE_A, 16'h0001);
        u_src.set_pins(1'b0, 3'h7);
        repeat (5) @(posedge clk);
        chk("legacy trip", {15'h0000, pda}, 16'h0001);
        chk("legacy irq", {15'h0000, irq}, 16'h0001);
        wr(meif_pkg::IDX_ENABLE_A, 16'h0000);
        repeat (2) @(posedge clk);
        chk("legacy trip gated", {15'h0000, pda}, 16'h0000);
        u_src.set_pins(1'b1, 3'h7);
        repeat (5) @(posedge clk);
        wr(meif_pkg::IDX_FLAGS_A, 16'h0001);
        rd(meif_pkg::IDX_FLAGS_A, 16'h0000, "legacy cleared");
        // Compatibility mode: enable only gates the interrupt
        wr(meif_pkg::IDX_COMPAT, 16'hFFFF);
        rd(meif_pkg::IDX_COMPAT, 16'h0001, "compat bits");
        chk("compat out", {15'h0000, compat}, 16'h0001);
        u_src.set_pins(1'b0, 3'h5);
        repeat (5) @(posedge clk);
        chk("compat trip", {15'h0000, pda}, 16'h0001);
        rd(meif_pkg::IDX_FLAGS_A, 16'h0000, "trip disabled");
        trip_en <= 3'h2;
        repeat (2) @(posedge clk);
        rd(meif_pkg::IDX_FLAGS_A, 16'h0001, "trip enabled");
        chk("compat irq off", {15'h0000, irq}, 16'h0000);
        wr(meif_pkg::IDX_ENABLE_A, 16'h0001);
        chk("compat irq on", {15'h0000, irq}, 16'h0001);
        // Upper lane only: the low byte of the enables must survive
        byteenable <= 4'h2;
        wr(meif_pkg::IDX_ENABLE_A, 16'hFFFF);
        rd(meif_pkg::IDX_ENABLE_A, 16'h0701, "upper lane only");
        byteenable <= 4'hF;
        $display("Test protection done");
        tally_and_finish();
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
